// ### rtca_map.vh
// Register map, field positions, reset values and timing for the alarm block
`ifndef RTCA_MAP_VH
`define RTCA_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RTCA_IDX_STATUS 6'h07
`define RTCA_IDX_CTRL 6'h08
`define RTCA_IDX_PWRC 6'h09
`define RTCA_IDX_TRIM 6'h0f
`define RTCA_IDX_ALARM 6'h10
`define RTCA_IDX_TSM 6'h16
`define RTCA_IDX_TSB 6'h1b
`define RTCA_IDX_DST 6'h20
`define RTCA_IDX_ISTAT 6'h30
`define RTCA_IDX_IMASK 6'h31

// ----------------------------------------------------------------
// Field counts and positions
// ----------------------------------------------------------------
`define RTCA_N_ALARM 6
`define RTCA_N_STAMP 5
`define RTCA_N_DST 8
`define RTCA_N_INT 3
`define RTCA_BIT_ALM 4
`define RTCA_BIT_AUTOCLR 7
`define RTCA_BIT_REPEAT 6
`define RTCA_BIT_FOUTEN 0
`define RTCA_BIT_STCLR 7
`define RTCA_BIT_MEN 7
`define RTCA_FLD_MSB 6
`define RTCA_TRIM_SIGN 4
`define RTCA_INT_ALARM 0
`define RTCA_INT_M2B 1
`define RTCA_INT_B2M 2

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define RTCA_ALARM_RST 8'h00
`define RTCA_ALARM_DAY_RST 8'h01
`define RTCA_ALARM_DATE_POS 3
`define RTCA_ALARM_MONTH_POS 4
`define RTCA_STAMP_RST 8'h00
`define RTCA_DST_RST 8'h00
`define RTCA_DST_MORV_RST 8'h10
`define RTCA_DST_MORV_IDX 4
`define RTCA_TRIM_MAX 4'ha

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTCA_CLK_MHZ 50
`define RTCA_PULSE_US 250

`endif

// ### rtca_dst_mem.v
// Small register-file memory holding the daylight-saving control bytes
`timescale 1ns/1ps
`include "rtca_map.vh"

module rtca_dst_mem #(
    parameter integer P_DEPTH = `RTCA_N_DST,
    parameter integer P_AW = 3,
    parameter integer P_DW = 8
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Access port
    input wire i_we,
    input wire [P_AW-1:0] i_addr,
    input wire [P_DW-1:0] i_wdata,
    output reg [P_DW-1:0] o_rdata
);

reg [P_DW-1:0] mem [0:P_DEPTH-1];
integer k;

// Read data always registered, one cycle after the address
always @(posedge i_clk_sys) begin
    if (i_rst) begin
        for (k = 0; k < P_DEPTH; k = k + 1) begin
            mem[k] <= (k == `RTCA_DST_MORV_IDX) ? `RTCA_DST_MORV_RST : `RTCA_DST_RST;
        end
        o_rdata <= `RTCA_DST_RST;
    end else begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
end

endmodule

// ### rtca_top.v
// Alarm, power time stamps and trim readback of the clock, behind APB
`timescale 1ns/1ps
`include "rtca_map.vh"

module rtca_top #(
    parameter integer P_PULSE_CYCLES = `RTCA_PULSE_US * `RTCA_CLK_MHZ,
    parameter integer P_CNT_W = 16
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    output wire o_pready,
    output reg [31:0] o_prdata,
    output wire o_pslverr,
    // Running calendar, same clock
    input wire i_cal_tick,
    input wire [7:0] i_cal_sec,
    input wire [7:0] i_cal_min,
    input wire [7:0] i_cal_hour,
    input wire [7:0] i_cal_date,
    input wire [7:0] i_cal_month,
    input wire [7:0] i_cal_wday,
    // Trim after temperature correction, same clock
    input wire [4:0] i_final_trim,
    // Supply monitor, asynchronous
    input wire i_on_battery,
    // Frequency output, same clock
    input wire i_fout,
    // Alarm pin and interrupt
    output reg o_alarm_pin_n,
    output wire o_irq
);

// ----------------------------------------------------------------
// APB access
// ----------------------------------------------------------------
// One wait state on every access lets read data come from a flop
wire [5:0] idx;
wire acc;
wire done;
wire wr;
wire rd;
wire [7:0] wb;
reg acc_wait;
reg mapped;
reg [7:0] rsel;

assign idx = i_paddr[7:2];
assign acc = i_psel & i_penable;
assign done = acc & acc_wait;
assign o_pready = done;
assign o_pslverr = done & ~mapped;
assign wr = done & i_pwrite & i_pstrb[0] & mapped;
assign rd = done & ~i_pwrite & mapped;
assign wb = i_pwdata[7:0];

always @(posedge i_clk_sys) begin
    if (i_rst) begin
        acc_wait <= 1'b0;
    end else begin
        acc_wait <= acc & ~acc_wait;
    end
end

// ----------------------------------------------------------------
// Control registers
// ----------------------------------------------------------------
reg auto_clear_on_read;
reg alarm_repeat_select;
reg fout_enable;
reg [`RTCA_N_INT-1:0] int_mask;
wire stamp_clear;

always @(posedge i_clk_sys) begin
    if (i_rst) begin
        auto_clear_on_read <= 1'b0;
        alarm_repeat_select <= 1'b0;
        fout_enable <= 1'b0;
        int_mask <= {`RTCA_N_INT{1'b0}};
    end else begin
        if (wr && idx == `RTCA_IDX_CTRL) begin
            auto_clear_on_read <= wb[`RTCA_BIT_AUTOCLR];
            alarm_repeat_select <= wb[`RTCA_BIT_REPEAT];
            fout_enable <= wb[`RTCA_BIT_FOUTEN];
        end
        if (wr && idx == `RTCA_IDX_IMASK) begin
            int_mask <= wb[`RTCA_N_INT-1:0];
        end
    end
end

assign stamp_clear = wr && idx == `RTCA_IDX_PWRC && wb[`RTCA_BIT_STCLR];

// ----------------------------------------------------------------
// Trim readback
// ----------------------------------------------------------------
reg [4:0] trim_view;

always @(posedge i_clk_sys) begin
    if (i_rst) begin
        trim_view <= 5'h00;
    end else if (i_final_trim[3:0] > `RTCA_TRIM_MAX) begin
        trim_view <= {i_final_trim[`RTCA_TRIM_SIGN], `RTCA_TRIM_MAX};
    end else begin
        trim_view <= i_final_trim;
    end
end

// ----------------------------------------------------------------
// Alarm compare
// ----------------------------------------------------------------
wire [47:0] cal_vec;
wire [47:0] alarm_vec;
wire [`RTCA_N_ALARM-1:0] fld_en;
wire [`RTCA_N_ALARM-1:0] fld_eq;
wire match;
wire trigger;
reg match_prev;
genvar g;

assign cal_vec = {i_cal_wday, i_cal_month, i_cal_date, i_cal_hour, i_cal_min, i_cal_sec};

generate
    for (g = 0; g < `RTCA_N_ALARM; g = g + 1) begin : g_alm
        reg [7:0] val;
        always @(posedge i_clk_sys) begin
            if (i_rst) begin
                if (g == `RTCA_ALARM_DATE_POS || g == `RTCA_ALARM_MONTH_POS) begin
                    val <= `RTCA_ALARM_DAY_RST;
                end else begin
                    val <= `RTCA_ALARM_RST;
                end
            end else if (wr && idx == `RTCA_IDX_ALARM + g) begin
                val <= wb;
            end
        end
        assign alarm_vec[g*8 +: 8] = val;
        assign fld_en[g] = val[`RTCA_BIT_MEN];
        assign fld_eq[g] = val[`RTCA_FLD_MSB:0] == cal_vec[g*8 +: `RTCA_FLD_MSB+1];
    end
endgenerate

assign match = (&(~fld_en | fld_eq)) & (|fld_en);

assign trigger = i_cal_tick & match & ~match_prev;

always @(posedge i_clk_sys) begin
    if (i_rst) begin
        match_prev <= 1'b0;
    end else if (i_cal_tick) begin
        match_prev <= match;
    end
end

// ----------------------------------------------------------------
// Alarm flag
// ----------------------------------------------------------------
reg alarm_flag;
reg next_alarm_flag;

always @* begin
    next_alarm_flag = alarm_flag;
    if (wr && idx == `RTCA_IDX_STATUS && !wb[`RTCA_BIT_ALM]) begin
        next_alarm_flag = 1'b0;
    end
    if (rd && idx == `RTCA_IDX_STATUS && auto_clear_on_read) begin
        next_alarm_flag = 1'b0;
    end
    if (trigger) begin
        next_alarm_flag = 1'b1;
    end
end

always @(posedge i_clk_sys) begin
    if (i_rst) begin
        alarm_flag <= 1'b0;
    end else begin
        alarm_flag <= next_alarm_flag;
    end
end

// ----------------------------------------------------------------
// Alarm pin sequencer
// ----------------------------------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_HOLD = 3'b010;
localparam ST_PULSE = 3'b100;
localparam [P_CNT_W-1:0] L_LOAD = P_PULSE_CYCLES[P_CNT_W-1:0];
localparam [P_CNT_W-1:0] L_ONE = {{(P_CNT_W-1){1'b0}}, 1'b1};

reg [2:0] state;
reg [2:0] next_state;
reg [P_CNT_W-1:0] cnt;
reg [P_CNT_W-1:0] next_cnt;
reg next_pin_n;

always @* begin
    next_state = state;
    next_cnt = cnt;
    case (state)
        ST_IDLE: begin
            if (trigger && alarm_repeat_select) begin
                next_state = ST_PULSE;
                next_cnt = L_LOAD;
            end else if (trigger) begin
                next_state = ST_HOLD;
            end
        end
        ST_HOLD: begin
            if (trigger && alarm_repeat_select) begin
                next_state = ST_PULSE;
                next_cnt = L_LOAD;
            end else if (!next_alarm_flag) begin
                next_state = ST_IDLE;
            end
        end
        ST_PULSE: begin
            if (trigger) begin
                next_cnt = L_LOAD;
            end else if (cnt <= L_ONE) begin
                next_state = ST_IDLE;
                next_cnt = {P_CNT_W{1'b0}};
            end else begin
                next_cnt = cnt - L_ONE;
            end
        end
        default: begin
            next_state = ST_IDLE;
            next_cnt = {P_CNT_W{1'b0}};
        end
    endcase
    // Frequency output owns the pin while enabled
    if (fout_enable) begin
        next_pin_n = i_fout;
    end else begin
        next_pin_n = (next_state == ST_IDLE);
    end
end

always @(posedge i_clk_sys) begin
    if (i_rst) begin
        state <= ST_IDLE;
        cnt <= {P_CNT_W{1'b0}};
        o_alarm_pin_n <= 1'b1;
    end else begin
        state <= next_state;
        cnt <= next_cnt;
        o_alarm_pin_n <= next_pin_n;
    end
end

// ----------------------------------------------------------------
// Supply switchover time stamps
// ----------------------------------------------------------------
// A battery level already high at reset release is seen as a switchover
reg bat_s1;
reg bat_s2;
reg bat_s3;
reg m2b_held;
wire to_bat;
wire to_main;
wire cap_m2b;
wire [39:0] stm_vec;
wire [39:0] stb_vec;

always @(posedge i_clk_sys) begin
    if (i_rst) begin
        bat_s1 <= 1'b0;
        bat_s2 <= 1'b0;
        bat_s3 <= 1'b0;
    end else begin
        bat_s1 <= i_on_battery;
        bat_s2 <= bat_s1;
        bat_s3 <= bat_s2;
    end
end

assign to_bat = bat_s2 & ~bat_s3;
assign to_main = ~bat_s2 & bat_s3;
assign cap_m2b = to_bat & (~m2b_held | stamp_clear);

always @(posedge i_clk_sys) begin
    if (i_rst) begin
        m2b_held <= 1'b0;
    end else if (cap_m2b) begin
        m2b_held <= 1'b1;
    end else if (stamp_clear) begin
        m2b_held <= 1'b0;
    end
end

generate
    for (g = 0; g < `RTCA_N_STAMP; g = g + 1) begin : g_ts
        reg [7:0] m2b;
        reg [7:0] b2m;
        always @(posedge i_clk_sys) begin
            if (i_rst) begin
                m2b <= `RTCA_STAMP_RST;
                b2m <= `RTCA_STAMP_RST;
            end else begin
                if (cap_m2b) begin
                    m2b <= cal_vec[g*8 +: 8];
                end else if (stamp_clear) begin
                    m2b <= `RTCA_STAMP_RST;
                end
                if (to_main) begin
                    b2m <= cal_vec[g*8 +: 8];
                end else if (stamp_clear) begin
                    b2m <= `RTCA_STAMP_RST;
                end
            end
        end
        assign stm_vec[g*8 +: 8] = m2b;
        assign stb_vec[g*8 +: 8] = b2m;
    end
endgenerate

// ----------------------------------------------------------------
// Daylight-saving bytes
// ----------------------------------------------------------------
wire [7:0] dst_rdata;
wire dst_hit;

assign dst_hit = idx >= `RTCA_IDX_DST && idx < `RTCA_IDX_DST + `RTCA_N_DST;

rtca_dst_mem #(
    .P_DEPTH(`RTCA_N_DST),
    .P_AW(3),
    .P_DW(8)
) u_dst (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(wr & dst_hit),
    .i_addr(idx[2:0]),
    .i_wdata(wb),
    .o_rdata(dst_rdata)
);

// ----------------------------------------------------------------
// Interrupt status
// ----------------------------------------------------------------
reg [`RTCA_N_INT-1:0] int_stat;
wire [`RTCA_N_INT-1:0] int_ev;
wire [`RTCA_N_INT-1:0] int_w1c;

assign int_ev[`RTCA_INT_ALARM] = trigger;
assign int_ev[`RTCA_INT_M2B] = cap_m2b;
assign int_ev[`RTCA_INT_B2M] = to_main;
assign int_w1c = (wr && idx == `RTCA_IDX_ISTAT) ? wb[`RTCA_N_INT-1:0] : {`RTCA_N_INT{1'b0}};
assign o_irq = |(int_stat & int_mask);

// New events win over a clear in the same cycle
always @(posedge i_clk_sys) begin
    if (i_rst) begin
        int_stat <= {`RTCA_N_INT{1'b0}};
    end else begin
        int_stat <= (int_stat & ~int_w1c) | int_ev;
    end
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
wire [5:0] aoff;
wire [5:0] moff;
wire [5:0] boff;

assign aoff = idx - `RTCA_IDX_ALARM;
assign moff = idx - `RTCA_IDX_TSM;
assign boff = idx - `RTCA_IDX_TSB;

always @* begin
    mapped = 1'b1;
    rsel = 8'h00;
    if (idx == `RTCA_IDX_STATUS) begin
        rsel[`RTCA_BIT_ALM] = alarm_flag;
    end else if (idx == `RTCA_IDX_CTRL) begin
        rsel[`RTCA_BIT_AUTOCLR] = auto_clear_on_read;
        rsel[`RTCA_BIT_REPEAT] = alarm_repeat_select;
        rsel[`RTCA_BIT_FOUTEN] = fout_enable;
    end else if (idx == `RTCA_IDX_PWRC) begin
        rsel = 8'h00;
    end else if (idx == `RTCA_IDX_TRIM) begin
        rsel = {3'h0, trim_view};
    end else if (idx >= `RTCA_IDX_ALARM && idx < `RTCA_IDX_TSM) begin
        rsel = alarm_vec[aoff[2:0]*8 +: 8];
    end else if (idx >= `RTCA_IDX_TSM && idx < `RTCA_IDX_TSB) begin
        rsel = stm_vec[moff[2:0]*8 +: 8];
    end else if (idx >= `RTCA_IDX_TSB && idx < `RTCA_IDX_TSB + `RTCA_N_STAMP) begin
        rsel = stb_vec[boff[2:0]*8 +: 8];
    end else if (dst_hit) begin
        rsel = dst_rdata;
    end else if (idx == `RTCA_IDX_ISTAT) begin
        rsel = {5'h00, int_stat};
    end else if (idx == `RTCA_IDX_IMASK) begin
        rsel = {5'h00, int_mask};
    end else begin
        mapped = 1'b0;
    end
end

// Read data latched on the first access cycle
always @(posedge i_clk_sys) begin
    if (i_rst) begin
        o_prdata <= 32'h00000000;
    end else if (acc && !acc_wait && !i_pwrite) begin
        o_prdata <= {24'h000000, rsel};
    end
end

endmodule

// ### rtca_cal_model.sv
// Calendar and supply source model feeding the alarm block
`timescale 1ns/1ps

module rtca_cal_model (
    // Clock
    input wire i_clk_sys,
    // Calendar {wday, month, date, hour, min, sec} and supply state
    output reg o_cal_tick,
    output reg [47:0] o_cal,
    output reg o_on_battery
);
    initial begin
        o_cal_tick = 1'b0;
        o_cal = 48'h00_01_01_00_00_00;
        o_on_battery = 1'b0;
    end
    // New calendar value with one-cycle tick
    task adv(input [47:0] v);
        begin
            @(posedge i_clk_sys);
            o_cal_tick <= 1'b1;
            o_cal <= v;
            @(posedge i_clk_sys);
            o_cal_tick <= 1'b0;
        end
    endtask
    // Supply level, resynchronised inside the block
    task supply(input b);
        begin
            @(posedge i_clk_sys);
            o_on_battery <= b;
        end
    endtask
endmodule

// ### rtca_top_checker.sv
// Port-level assertions for the alarm block
`timescale 1ns/1ps
`include "rtca_map.vh"

module rtca_top_checker (
    // Clock and reset
    input logic i_clk_sys,
    input logic i_rst,
    // APB
    input logic i_psel,
    input logic i_penable,
    input logic i_pwrite,
    input logic [7:0] i_paddr,
    input logic o_pready,
    input logic [31:0] o_prdata,
    input logic o_pslverr,
    // Alarm side
    input logic i_cal_tick,
    input logic o_alarm_pin_n,
    input logic o_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_access;
        i_psel && !i_penable ##1 i_psel && i_penable;
    endsequence
    sequence s_read_done;
        o_pready && !i_pwrite;
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_ready_wait: assert property (s_access |-> !o_pready ##1 o_pready)
        else $error("ready not in second access cycle");
    a_ready_qual: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside an access");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_rdata_upper: assert property (s_read_done |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_trim_upper: assert property (s_read_done and i_paddr[7:2] == `RTCA_IDX_TRIM
        |-> o_prdata[7:5] == 3'b000 && o_prdata[3:0] <= 4'ha)
        else $error("trim readback out of range");
    a_unmapped_zero: assert property (s_read_done and o_pslverr |-> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    a_pin_cause: assert property ($fell(o_alarm_pin_n)
        && !$past(o_pready && i_pwrite) |-> $past(i_cal_tick) || $past(i_cal_tick, 2))
        else $error("alarm pin fell without calendar tick");
    a_reset_idle: assert property (disable iff (1'b0)
        i_rst |=> o_alarm_pin_n && !o_pready && !o_irq)
        else $error("outputs not idle after reset");
endmodule

bind rtca_top rtca_top_checker rtca_top_checker_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_cal_tick(i_cal_tick), .o_alarm_pin_n(o_alarm_pin_n),
    .o_irq(o_irq)
);

// ### rtca_top_bench.sv
// Self-checking bench for the alarm, stamp and trim block
`timescale 1ns/1ps
`include "rtca_map.vh"

module rtca_top_bench;
    // Short repeat pulse keeps the run brief
    localparam integer P_PULSE = 10;
    reg i_clk_sys = 1'b0;
    reg i_rst = 1'b1;
    reg i_psel = 1'b0;
    reg i_penable = 1'b0;
    reg i_pwrite = 1'b0;
    reg [7:0] i_paddr = 8'h00;
    reg [31:0] i_pwdata = 32'h0;
    reg [3:0] i_pstrb = 4'h1;
    reg [4:0] i_final_trim = 5'h00;
    reg i_fout = 1'b1;
    wire o_pready;
    wire [31:0] o_prdata;
    wire o_pslverr;
    wire o_alarm_pin_n;
    wire o_irq;
    wire cal_tick;
    wire [47:0] cal;
    wire [7:0] cal_sec = cal[7:0];
    wire [7:0] cal_min = cal[15:8];
    wire [7:0] cal_hour = cal[23:16];
    wire [7:0] cal_date = cal[31:24];
    wire [7:0] cal_month = cal[39:32];
    wire [7:0] cal_wday = cal[47:40];
    wire on_batt;
    integer miscompares = 0;
    integer n_compared = 0;
    integer cycles = 0;
    integer k;
    integer n;
    reg [7:0] rd;
    reg er;
    reg [4:0] tv [0:3];

    rtca_top #(.P_PULSE_CYCLES(P_PULSE)) rtca_top_i (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .i_cal_tick(cal_tick), .i_cal_sec(cal_sec), .i_cal_min(cal_min),
        .i_cal_hour(cal_hour), .i_cal_date(cal_date), .i_cal_month(cal_month),
        .i_cal_wday(cal_wday), .i_final_trim(i_final_trim), .i_on_battery(on_batt),
        .i_fout(i_fout), .o_alarm_pin_n(o_alarm_pin_n), .o_irq(o_irq)
    );
    rtca_cal_model rtca_cal_model_i (
        .i_clk_sys(i_clk_sys), .o_cal_tick(cal_tick), .o_cal(cal), .o_on_battery(on_batt)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Data taken at the ready edge; returns at a falling edge so effects have landed
    task apb(input w, input [5:0] idx, input [7:0] wd);
        begin
            @(posedge i_clk_sys);
            i_psel <= 1'b1;
            i_penable <= 1'b0;
            i_pwrite <= w;
            i_paddr <= {idx, 2'b00};
            i_pwdata <= {24'h0, wd};
            @(posedge i_clk_sys);
            i_penable <= 1'b1;
            @(posedge i_clk_sys);
            while (o_pready !== 1'b1) @(posedge i_clk_sys);
            rd = o_prdata[7:0];
            er = o_pslverr;
            i_psel <= 1'b0;
            i_penable <= 1'b0;
            @(negedge i_clk_sys);
        end
    endtask
    task rchk(input [5:0] idx, input [7:0] exp);
        begin
            apb(1'b0, idx, 8'h00);
            chk({24'h0, rd}, {24'h0, exp});
        end
    endtask
    task stchk(input [5:0] idx, input [39:0] v);
        integer j;
        begin
            for (j = 0; j < 5; j = j + 1) rchk(idx + j, v[8*j+:8]);
        end
    endtask
    task adv_settle(input [47:0] v);
        begin
            rtca_cal_model_i.adv(v);
            repeat (2) @(posedge i_clk_sys);
            @(negedge i_clk_sys);
        end
    endtask
    task batt(input b);
        begin
            rtca_cal_model_i.supply(b);
            repeat (6) @(posedge i_clk_sys);
        end
    endtask
    task end_of_test;
        begin
            $display("compared %0d, miscompares %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and tests
    // ------------------------------------------------------------
    initial forever #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            end_of_test;
        end
    end
    initial begin
        tv[0] = 5'h00;
        tv[1] = 5'h0a;
        tv[2] = 5'h10;
        tv[3] = 5'h1a;
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        for (k = 0; k < 6; k = k + 1) begin
            rchk(`RTCA_IDX_ALARM + k, (k == 3 || k == 4) ? 8'h01 : 8'h00);
        end
        for (k = 0; k < 10; k = k + 1) rchk(`RTCA_IDX_TSM + k, 8'h00);
        rchk(`RTCA_IDX_DST + 4, 8'h10);
        chk(o_alarm_pin_n, 1);
        $display("reset values done");
        for (k = 0; k < 4; k = k + 1) begin
            @(posedge i_clk_sys);
            i_final_trim <= tv[k];
            rchk(`RTCA_IDX_TRIM, {3'b000, tv[k]});
        end
        // Magnitude above ten saturates, sign kept
        @(posedge i_clk_sys);
        i_final_trim <= 5'h1f;
        rchk(`RTCA_IDX_TRIM, 8'h1a);
        apb(1'b1, `RTCA_IDX_TRIM, 8'h05);
        rchk(`RTCA_IDX_TRIM, 8'h1a);
        apb(1'b0, 6'h3f, 8'h00);
        chk({er, rd}, 9'h100);
        for (k = 0; k < 8; k = k + 1) apb(1'b1, `RTCA_IDX_DST + k, 8'h30 + k);
        @(posedge i_clk_sys);
        i_pstrb <= 4'h0;
        apb(1'b1, `RTCA_IDX_DST, 8'hff);
        @(posedge i_clk_sys);
        i_pstrb <= 4'h1;
        for (k = 0; k < 8; k = k + 1) rchk(`RTCA_IDX_DST + k, 8'h30 + k);
        $display("trim and storage done");
        apb(1'b1, `RTCA_IDX_IMASK, 8'h01);
        apb(1'b1, `RTCA_IDX_ALARM + 1, 8'hb0);
        adv_settle(48'h03_01_01_11_29_59);
        rchk(`RTCA_IDX_STATUS, 8'h00);
        adv_settle(48'h03_01_01_11_30_00);
        chk({o_alarm_pin_n, o_irq}, 2'b01);
        adv_settle(48'h03_01_01_11_30_01);
        rchk(`RTCA_IDX_STATUS, 8'h10);
        apb(1'b1, `RTCA_IDX_STATUS, 8'h10);
        chk(o_alarm_pin_n, 0);
        apb(1'b1, `RTCA_IDX_STATUS, 8'h00);
        chk(o_alarm_pin_n, 1);
        rchk(`RTCA_IDX_ISTAT, 8'h01);
        apb(1'b1, `RTCA_IDX_IMASK, 8'h00);
        chk(o_irq, 0);
        apb(1'b1, `RTCA_IDX_IMASK, 8'h01);
        chk(o_irq, 1);
        apb(1'b1, `RTCA_IDX_ISTAT, 8'h01);
        chk(o_irq, 0);
        apb(1'b1, `RTCA_IDX_CTRL, 8'h80);
        adv_settle(48'h03_01_01_11_31_00);
        apb(1'b1, `RTCA_IDX_ALARM + 1, 8'hb2);
        adv_settle(48'h03_01_01_11_32_00);
        rchk(`RTCA_IDX_STATUS, 8'h10);
        rchk(`RTCA_IDX_STATUS, 8'h00);
        chk(o_alarm_pin_n, 1);
        $display("single alarm done");
        apb(1'b1, `RTCA_IDX_CTRL, 8'h40);
        apb(1'b1, `RTCA_IDX_ALARM + 1, 8'h00);
        apb(1'b1, `RTCA_IDX_ALARM, 8'hb0);
        for (k = 0; k < 2; k = k + 1) begin
            rtca_cal_model_i.adv(48'h03_01_01_11_40_29);
            rtca_cal_model_i.adv(48'h03_01_01_11_40_30);
            while (o_alarm_pin_n === 1'b1) @(negedge i_clk_sys);
            n = 0;
            while (o_alarm_pin_n === 1'b0) begin
                n = n + 1;
                @(negedge i_clk_sys);
            end
            chk(n, P_PULSE);
        end
        rchk(`RTCA_IDX_STATUS, 8'h10);
        // Frequency output owns the pin: a one-shot match leaves it at the input level
        apb(1'b1, `RTCA_IDX_CTRL, 8'h01);
        rtca_cal_model_i.adv(48'h03_01_01_11_41_29);
        adv_settle(48'h03_01_01_11_41_30);
        chk(o_alarm_pin_n, 1);
        rchk(`RTCA_IDX_STATUS, 8'h10);
        apb(1'b1, `RTCA_IDX_STATUS, 8'h00);
        apb(1'b1, `RTCA_IDX_CTRL, 8'h00);
        chk(o_alarm_pin_n, 1);
        apb(1'b1, `RTCA_IDX_ALARM, 8'h00);
        $display("repeat alarm done");
        rtca_cal_model_i.adv(48'h02_08_07_05_22_11);
        batt(1'b1);
        stchk(`RTCA_IDX_TSM, 40'h08_07_05_22_11);
        rtca_cal_model_i.adv(48'h04_10_09_06_44_33);
        batt(1'b0);
        stchk(`RTCA_IDX_TSB, 40'h10_09_06_44_33);
        rtca_cal_model_i.adv(48'h05_11_12_07_56_55);
        batt(1'b1);
        stchk(`RTCA_IDX_TSM, 40'h08_07_05_22_11);
        rtca_cal_model_i.adv(48'h06_12_13_08_58_57);
        batt(1'b0);
        stchk(`RTCA_IDX_TSB, 40'h12_13_08_58_57);
        rchk(`RTCA_IDX_ISTAT, 8'h07);
        apb(1'b1, `RTCA_IDX_PWRC, 8'h80);
        for (k = 0; k < 10; k = k + 1) rchk(`RTCA_IDX_TSM + k, 8'h00);
        rchk(`RTCA_IDX_PWRC, 8'h00);
        $display("time stamps done");
        end_of_test;
    end
endmodule
